// *** pam_pkg.sv ***
// constants shared by the port-A pin 8..12 function-select block
package pam_pkg;

	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [31:0] PAM_ADDR_FUNC_SEL = 32'h0000_0000;
	localparam logic [31:0] PAM_ADDR_MAP_CFG = 32'h0000_0004;
	localparam logic [31:0] PAM_ADDR_PROT = 32'h0000_0008;
	localparam logic [31:0] PAM_ADDR_PIN_LVL = 32'h0000_000c;

	// ---------------------------------------------------------------
	// field layout and reset values
	// ---------------------------------------------------------------
	localparam int PAM_NUM_PINS = 5;
	localparam int PAM_NUM_CODES = 4;
	localparam int PAM_FIELD_W = 2;
	localparam int PAM_FIELD_LSB = 16;
	localparam int PAM_MODE_LSB = 0;
	localparam int PAM_MODE_W = 2;
	localparam int PAM_PROT_BIT = 0;
	localparam logic [31:0] PAM_FUNC_SEL_MASK = 32'h03ff_0000;
	localparam logic [31:0] PAM_FUNC_SEL_RST = 32'h0000_0000;
	localparam logic [1:0] PAM_MODE_RST = 2'h0;
	localparam logic [1:0] PAM_MODE_REMAP = 2'h3;
	localparam logic PAM_PROT_RST = 1'b0;

	// pin indices inside the five-pin group
	localparam int PAM_PIN8 = 0;
	localparam int PAM_PIN9 = 1;
	localparam int PAM_PIN10 = 2;
	localparam int PAM_PIN11 = 3;
	localparam int PAM_PIN12 = 4;

	// ---------------------------------------------------------------
	// function codes of one 2-bit field
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		PAM_FN_GPIO = 2'h0,
		PAM_FN_ALT_A = 2'h1,
		PAM_FN_ALT_B = 2'h2,
		PAM_FN_ALT_C = 2'h3
	} pam_func_t;

	// ---------------------------------------------------------------
	// levels presented to peripherals whose pin is not selected
	// ---------------------------------------------------------------
	localparam logic PAM_RX_IDLE = 1'b1;
	localparam logic PAM_TZ_IDLE = 1'b1;
	localparam logic PAM_CAP_IDLE = 1'b0;
	localparam logic PAM_SPI_IDLE = 1'b0;

	// ---------------------------------------------------------------
	// bus encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] PAM_HTRANS_NONSEQ = 2'h2;
	localparam logic PAM_HRESP_OKAY = 1'b0;
	localparam logic [31:0] PAM_RDATA_ZERO = 32'h0000_0000;

endpackage : pam_pkg

// *** pam_sync2.sv ***
// two-flop synchroniser for pad levels
`timescale 1ns/1ps
module pam_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// async level in, synchronised level out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (!rstn) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : pam_sync2

// *** pam_pin_cell.sv ***
// one pad's output mux: picks data and enable by the 2-bit function code
`timescale 1ns/1ps
module pam_pin_cell (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// function code
	input wire logic [1:0] sel,
	// candidate sources, indexed by code
	input wire logic [3:0] cand_out,
	input wire logic [3:0] cand_oe,
	// pad drive
	output logic pin_out,
	output logic pin_oe_n
);
	// registered so the pad never sees a decode glitch
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pin_out <= 1'b0;
			pin_oe_n <= 1'b1;
		end else begin
			pin_out <= cand_out[sel];
			pin_oe_n <= ~cand_oe[sel];
		end
	end
endmodule : pam_pin_cell

// *** pam_top.sv ***
// port-A pins 8..12 function select with AHB-Lite register access
//
// How it works
// - a field holding 00 gives its pin to plain general-purpose I/O, which is also the reset choice.
// - pin 12 at 01 is trip-zone input one, or pwm twelve output A when remapping mode 11 is active.
// - pin 12 at 10 drives the second CAN transmit and at 11 carries the second SPI slave-in master-out.
// - pin 11 at 01 is pwm six output B, or pwm twelve output A under remapping.
// - pin 11 at 10 feeds the second SCI receive and at 11 connects capture unit four.
// - pin 10 at 01 is pwm six output A, or pwm eleven output A under remapping.
// - pin 10 at 10 feeds the second CAN receive and at 11 drives ADC start-of-conversion B.
// - pin 9 at 01 is pwm five output B, or pwm ten output A under remapping.
// - pin 9 at 10 drives the second SCI transmit and at 11 connects capture unit three.
// - pin 8 at 01 is pwm five output A, or pwm nine output A under remapping.
// - pin 8 at 10 drives the second CAN transmit and at 11 drives ADC start-of-conversion A.
// - a reserved option gives undefined pin state, so every code is simply routed as listed.
// - writes to the select registers land only while the protected write enable is set.
`timescale 1ns/1ps
module pam_top #(
	parameter bit REMAP_VARIANT = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// pads, index 0 is pin 8 .. index 4 is pin 12
	input wire logic [pam_pkg::PAM_NUM_PINS-1:0] pin_in,
	output logic [pam_pkg::PAM_NUM_PINS-1:0] pin_out,
	output logic [pam_pkg::PAM_NUM_PINS-1:0] pin_oe_n,
	// general-purpose i/o core
	input wire logic [pam_pkg::PAM_NUM_PINS-1:0] gpio_out,
	input wire logic [pam_pkg::PAM_NUM_PINS-1:0] gpio_oe,
	output logic [pam_pkg::PAM_NUM_PINS-1:0] gpio_in,
	// pwm outputs
	input wire logic pwm_five_out_a,
	input wire logic pwm_five_out_b,
	input wire logic pwm_six_out_a,
	input wire logic pwm_six_out_b,
	input wire logic pwm_nine_out_a,
	input wire logic pwm_ten_out_a,
	input wire logic pwm_eleven_out_a,
	input wire logic pwm_twelve_out_a,
	// trip zone
	output logic trip_zone_input_one,
	// second can and sci
	input wire logic can_second_transmit,
	output logic can_second_receive,
	input wire logic sci_second_transmit,
	output logic sci_second_receive,
	// second spi, bidirectional data line
	input wire logic spi_second_slave_in_master_out,
	input wire logic spi_second_simo_oe,
	output logic spi_second_simo_in,
	// capture units, bidirectional
	input wire logic capture_unit_three,
	input wire logic capture_unit_three_oe,
	output logic capture_unit_three_in,
	input wire logic capture_unit_four,
	input wire logic capture_unit_four_oe,
	output logic capture_unit_four_in,
	// adc start-of-conversion strobes
	input wire logic adc_start_conv_a_out,
	input wire logic adc_start_conv_b_out
);
	import pam_pkg::*;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [1:0] field_of(input logic [31:0] sel_reg, input int idx);
		field_of = sel_reg[PAM_FIELD_LSB + idx * PAM_FIELD_W +: PAM_FIELD_W];
	endfunction : field_of

	function automatic logic addr_is(input logic [31:0] a, input logic [31:0] ref_addr);
		addr_is = (a == ref_addr);
	endfunction : addr_is

	// a peripheral input sees its pad only while its code is selected
	function automatic logic route_in(input logic hit, input logic pad, input logic idle);
		route_in = hit ? pad : idle;
	endfunction : route_in

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [31:0] port_a_low_pin_function_select_r;
	logic [1:0] pwm_mapping_mode_r;
	logic protected_write_enable_r;

	// bus state
	logic wr_pend_r;
	logic [31:0] wr_addr_r;
	logic [31:0] hrdata_r;
	logic addr_take;
	logic [31:0] rd_mux;

	// pad side
	logic [PAM_NUM_PINS-1:0] pin_sync;
	logic remap;
	logic [1:0] sel [PAM_NUM_PINS];
	logic [3:0] cand_out [PAM_NUM_PINS];
	logic [3:0] cand_oe [PAM_NUM_PINS];

	// ---------------------------------------------------------------
	// ahb-lite slave: zero wait states, always OKAY
	// ---------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = PAM_HRESP_OKAY;
	assign hrdata = hrdata_r;
	assign addr_take = hsel && hready && (htrans == PAM_HTRANS_NONSEQ);

	// hsize is not checked; every access is handled as a full word
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_pend_r <= 1'b0;
		end else begin
			wr_pend_r <= addr_take && hwrite;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_addr_r <= PAM_RDATA_ZERO;
		end else if (addr_take) begin
			wr_addr_r <= haddr;
		end
	end

	// read value chosen in the address phase so hrdata comes from a flop
	// limitation: a read right behind a write to the same word returns the old value
	always_comb begin
		rd_mux = PAM_RDATA_ZERO;
		if (addr_is(haddr, PAM_ADDR_FUNC_SEL)) begin
			rd_mux = port_a_low_pin_function_select_r;
		end else if (addr_is(haddr, PAM_ADDR_MAP_CFG)) begin
			rd_mux[PAM_MODE_LSB +: PAM_MODE_W] = pwm_mapping_mode_r;
		end else if (addr_is(haddr, PAM_ADDR_PROT)) begin
			rd_mux[PAM_PROT_BIT] = protected_write_enable_r;
		end else if (addr_is(haddr, PAM_ADDR_PIN_LVL)) begin
			rd_mux[PAM_NUM_PINS-1:0] = pin_sync;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			hrdata_r <= PAM_RDATA_ZERO;
		end else if (addr_take && !hwrite) begin
			hrdata_r <= rd_mux;
		end
	end

	// ---------------------------------------------------------------
	// register writes
	// ---------------------------------------------------------------
	// the enable itself is never protected, else it could not be raised
	always_ff @(posedge clk) begin
		if (!rstn) begin
			protected_write_enable_r <= PAM_PROT_RST;
		end else if (wr_pend_r && addr_is(wr_addr_r, PAM_ADDR_PROT)) begin
			protected_write_enable_r <= hwdata[PAM_PROT_BIT];
		end
	end

	// only the pin 8..12 fields are held; the rest of the word reads zero
	always_ff @(posedge clk) begin
		if (!rstn) begin
			port_a_low_pin_function_select_r <= PAM_FUNC_SEL_RST;
		end else if (wr_pend_r && protected_write_enable_r && addr_is(wr_addr_r, PAM_ADDR_FUNC_SEL)) begin
			port_a_low_pin_function_select_r <= hwdata & PAM_FUNC_SEL_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pwm_mapping_mode_r <= PAM_MODE_RST;
		end else if (wr_pend_r && protected_write_enable_r && addr_is(wr_addr_r, PAM_ADDR_MAP_CFG)) begin
			pwm_mapping_mode_r <= hwdata[PAM_MODE_LSB +: PAM_MODE_W];
		end
	end

	// ---------------------------------------------------------------
	// pad input synchronisation
	// ---------------------------------------------------------------
	pam_sync2 #(
		.W(PAM_NUM_PINS)
	) u_pin_sync (
		.clk(clk),
		.rstn(rstn),
		.d(pin_in),
		.q(pin_sync)
	);

	// ---------------------------------------------------------------
	// output candidate tables
	// ---------------------------------------------------------------
	// only mode 11 remaps; the other mode values keep the normal choice
	assign remap = REMAP_VARIANT && (pwm_mapping_mode_r == PAM_MODE_REMAP);

	always_comb begin
		for (int p = 0; p < PAM_NUM_PINS; p++) begin
			sel[p] = field_of(port_a_low_pin_function_select_r, p);
			// code 00 hands the pad to the gpio core
			cand_out[p][PAM_FN_GPIO] = gpio_out[p];
			cand_oe[p][PAM_FN_GPIO] = gpio_oe[p];
		end

		// pin 8
		cand_out[PAM_PIN8][PAM_FN_ALT_A] = remap ? pwm_nine_out_a : pwm_five_out_a;
		cand_oe[PAM_PIN8][PAM_FN_ALT_A] = 1'b1;
		cand_out[PAM_PIN8][PAM_FN_ALT_B] = can_second_transmit;
		cand_oe[PAM_PIN8][PAM_FN_ALT_B] = 1'b1;
		cand_out[PAM_PIN8][PAM_FN_ALT_C] = adc_start_conv_a_out;
		cand_oe[PAM_PIN8][PAM_FN_ALT_C] = 1'b1;

		// pin 9
		cand_out[PAM_PIN9][PAM_FN_ALT_A] = remap ? pwm_ten_out_a : pwm_five_out_b;
		cand_oe[PAM_PIN9][PAM_FN_ALT_A] = 1'b1;
		cand_out[PAM_PIN9][PAM_FN_ALT_B] = sci_second_transmit;
		cand_oe[PAM_PIN9][PAM_FN_ALT_B] = 1'b1;
		cand_out[PAM_PIN9][PAM_FN_ALT_C] = capture_unit_three;
		cand_oe[PAM_PIN9][PAM_FN_ALT_C] = capture_unit_three_oe;

		// pin 10: receive input leaves the pad undriven
		cand_out[PAM_PIN10][PAM_FN_ALT_A] = remap ? pwm_eleven_out_a : pwm_six_out_a;
		cand_oe[PAM_PIN10][PAM_FN_ALT_A] = 1'b1;
		cand_out[PAM_PIN10][PAM_FN_ALT_B] = 1'b0;
		cand_oe[PAM_PIN10][PAM_FN_ALT_B] = 1'b0;
		cand_out[PAM_PIN10][PAM_FN_ALT_C] = adc_start_conv_b_out;
		cand_oe[PAM_PIN10][PAM_FN_ALT_C] = 1'b1;

		// pin 11
		cand_out[PAM_PIN11][PAM_FN_ALT_A] = remap ? pwm_twelve_out_a : pwm_six_out_b;
		cand_oe[PAM_PIN11][PAM_FN_ALT_A] = 1'b1;
		cand_out[PAM_PIN11][PAM_FN_ALT_B] = 1'b0;
		cand_oe[PAM_PIN11][PAM_FN_ALT_B] = 1'b0;
		cand_out[PAM_PIN11][PAM_FN_ALT_C] = capture_unit_four;
		cand_oe[PAM_PIN11][PAM_FN_ALT_C] = capture_unit_four_oe;

		// pin 12: trip zone is input-only, remapped pwm is an output
		cand_out[PAM_PIN12][PAM_FN_ALT_A] = remap ? pwm_twelve_out_a : 1'b0;
		cand_oe[PAM_PIN12][PAM_FN_ALT_A] = remap;
		cand_out[PAM_PIN12][PAM_FN_ALT_B] = can_second_transmit;
		cand_oe[PAM_PIN12][PAM_FN_ALT_B] = 1'b1;
		cand_out[PAM_PIN12][PAM_FN_ALT_C] = spi_second_slave_in_master_out;
		cand_oe[PAM_PIN12][PAM_FN_ALT_C] = spi_second_simo_oe;
	end

	// ---------------------------------------------------------------
	// pad drivers
	// ---------------------------------------------------------------
	// reserved codes route like any other code; no extra guard logic
	for (genvar g = 0; g < PAM_NUM_PINS; g++) begin : g_pin
		pam_pin_cell u_cell (
			.clk(clk),
			.rstn(rstn),
			.sel(sel[g]),
			.cand_out(cand_out[g]),
			.cand_oe(cand_oe[g]),
			.pin_out(pin_out[g]),
			.pin_oe_n(pin_oe_n[g])
		);
	end

	// ---------------------------------------------------------------
	// peripheral inputs
	// ---------------------------------------------------------------
	// unselected inputs sit at their idle level so no false trip or start bit
	// gpio core always sees the pad, whatever the selection
	always_ff @(posedge clk) begin
		if (!rstn) begin
			gpio_in <= '0;
		end else begin
			gpio_in <= pin_sync;
		end
	end

	// a low trip input would shut the pwm outputs down, so it idles high
	always_ff @(posedge clk) begin
		if (!rstn) begin
			trip_zone_input_one <= PAM_TZ_IDLE;
		end else begin
			trip_zone_input_one <= route_in(sel[PAM_PIN12] == PAM_FN_ALT_A && !remap,
				pin_sync[PAM_PIN12], PAM_TZ_IDLE);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			spi_second_simo_in <= PAM_SPI_IDLE;
		end else begin
			spi_second_simo_in <= route_in(sel[PAM_PIN12] == PAM_FN_ALT_C,
				pin_sync[PAM_PIN12], PAM_SPI_IDLE);
		end
	end

	// receive lines idle high, the line state between frames
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sci_second_receive <= PAM_RX_IDLE;
		end else begin
			sci_second_receive <= route_in(sel[PAM_PIN11] == PAM_FN_ALT_B,
				pin_sync[PAM_PIN11], PAM_RX_IDLE);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			capture_unit_four_in <= PAM_CAP_IDLE;
		end else begin
			capture_unit_four_in <= route_in(sel[PAM_PIN11] == PAM_FN_ALT_C,
				pin_sync[PAM_PIN11], PAM_CAP_IDLE);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			can_second_receive <= PAM_RX_IDLE;
		end else begin
			can_second_receive <= route_in(sel[PAM_PIN10] == PAM_FN_ALT_B,
				pin_sync[PAM_PIN10], PAM_RX_IDLE);
		end
	end

	// capture inputs idle low so a deselected pin records no edge
	always_ff @(posedge clk) begin
		if (!rstn) begin
			capture_unit_three_in <= PAM_CAP_IDLE;
		end else begin
			capture_unit_three_in <= route_in(sel[PAM_PIN9] == PAM_FN_ALT_C,
				pin_sync[PAM_PIN9], PAM_CAP_IDLE);
		end
	end

endmodule : pam_top

// *** pam_top_asserts.sv ***
// assertion checker bound to the pin 8..12 function-select top
`timescale 1ns/1ps
module pam_top_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	// pads and peripheral inputs
	input wire logic [pam_pkg::PAM_NUM_PINS-1:0] pin_in,
	input wire logic [pam_pkg::PAM_NUM_PINS-1:0] pin_oe_n,
	input wire logic [pam_pkg::PAM_NUM_PINS-1:0] gpio_in,
	input wire logic trip_zone_input_one,
	input wire logic can_second_receive,
	input wire logic sci_second_receive,
	input wire logic spi_second_simo_oe,
	input wire logic spi_second_simo_in,
	input wire logic capture_unit_four_oe,
	input wire logic capture_unit_four_in
);
	import pam_pkg::*;
	// edges since release; the pad chain needs three clean ones
	logic [2:0] live_r;
	always_ff @(posedge clk) begin
		if (!rstn)
			live_r <= 3'h0;
		else if (live_r != 3'h7)
			live_r <= live_r + 3'h1;
	end
	default clocking dcb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence rd_taken;
		hsel && hready && htrans == PAM_HTRANS_NONSEQ && !hwrite;
	endsequence
	sequence rd_unmapped;
		rd_taken ##0 haddr > PAM_ADDR_PIN_LVL;
	endsequence
	chk_ready_const: assert property (hreadyout)
		else $error("hreadyout dropped");
	chk_reset_pads: assert property ($past(!rstn) |-> pin_oe_n == 5'h1f && hrdata == 32'h0)
		else $error("pads not released after reset");
	chk_gpio_sync: assert property (live_r > 3'h3 |-> gpio_in == $past(pin_in, 3))
		else $error("gpio level not three edges behind pad");
	chk_tz_undriven: assert property (!trip_zone_input_one |-> pin_oe_n[PAM_PIN12])
		else $error("pin 12 driven while trip zone selected");
	chk_canrx_undriven: assert property (!can_second_receive |-> pin_oe_n[PAM_PIN10])
		else $error("pin 10 driven while can receive selected");
	chk_scirx_undriven: assert property (!sci_second_receive |-> pin_oe_n[PAM_PIN11])
		else $error("pin 11 driven while sci receive selected");
	chk_spi_oe: assert property (spi_second_simo_in |-> pin_oe_n[PAM_PIN12] == !$past(spi_second_simo_oe))
		else $error("pin 12 enable not following spi");
	chk_cap_oe: assert property (capture_unit_four_in |-> pin_oe_n[PAM_PIN11] == !$past(capture_unit_four_oe))
		else $error("pin 11 enable not following capture");
	chk_rdata_hold: assert property (!(hsel && hready && htrans == PAM_HTRANS_NONSEQ && !hwrite) |=> $stable(hrdata))
		else $error("read data moved without a read");
	chk_unmapped_rd: assert property (rd_unmapped |=> hrdata == PAM_RDATA_ZERO)
		else $error("unmapped read not zero");
endmodule : pam_top_asserts

bind pam_top pam_top_asserts u_chk (
	.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .pin_in(pin_in), .pin_oe_n(pin_oe_n), .gpio_in(gpio_in),
	.trip_zone_input_one(trip_zone_input_one), .can_second_receive(can_second_receive),
	.sci_second_receive(sci_second_receive), .spi_second_simo_oe(spi_second_simo_oe),
	.spi_second_simo_in(spi_second_simo_in), .capture_unit_four_oe(capture_unit_four_oe),
	.capture_unit_four_in(capture_unit_four_in)
);

// *** pam_periph_model.sv ***
// peripherals and board around pins 8..12
`timescale 1ns/1ps
module pam_periph_model (
	// clock and random feed
	input wire logic clk,
	input wire logic [31:0] rnd,
	// pad drive from the mux
	input wire logic [4:0] pin_out,
	input wire logic [4:0] pin_oe_n,
	// peripheral sources and resolved pads
	output logic [27:0] src,
	output logic [4:0] pin_in
);
	logic [4:0] ext_r;
	// sources take a fresh random pattern every cycle so stale routing cannot hide
	// every peripheral behind the mux exists here, so no picked option is reserved
	always @(posedge clk) begin
		src <= rnd[27:0];
		ext_r <= {rnd[31:28], rnd[0]};
	end
	// a free pad floats to a fresh pattern, never the last driven level
	always_comb begin
		for (int i = 0; i < 5; i++)
			pin_in[i] = pin_oe_n[i] !== 1'b0 ? ext_r[i] : pin_out[i];
	end
endmodule : pam_periph_model

// *** port_a_pins8_12_func_select_tb.sv ***
// self-checking bench for the pin 8..12 function-select block
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module port_a_pins8_12_func_select_tb;
	import pam_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rnd = 32'hffa8;
	logic [31:0] rd;
	logic hreadyout, hresp;
	logic [31:0] hrdata;
	logic [27:0] src;
	logic [4:0] pin_in, pin_out, pin_oe_n, gpio_in, s1, s2, g;
	logic [5:0] per_in, e_in;
	logic [1:0] e_dr [5];
	logic [31:0] regs [5] = '{PAM_ADDR_FUNC_SEL, PAM_ADDR_MAP_CFG, PAM_ADDR_PROT, PAM_ADDR_PIN_LVL, 32'h10};
	int error_cnt = 0;
	int cmp_count = 0;
	int m_sel, m_mode, m_prot;
	bit started;
	always #5 clk = ~clk;
	pam_periph_model u_per (.clk(clk), .rnd(rnd), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .src(src), .pin_in(pin_in));
	pam_top dut (
		.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .gpio_out(src[4:0]), .gpio_oe(src[9:5]),
		.gpio_in(gpio_in), .pwm_five_out_a(src[10]), .pwm_five_out_b(src[11]), .pwm_six_out_a(src[12]),
		.pwm_six_out_b(src[13]), .pwm_nine_out_a(src[14]), .pwm_ten_out_a(src[15]), .pwm_eleven_out_a(src[16]),
		.pwm_twelve_out_a(src[17]), .trip_zone_input_one(per_in[5]), .can_second_transmit(src[18]),
		.can_second_receive(per_in[4]), .sci_second_transmit(src[19]), .sci_second_receive(per_in[3]),
		.spi_second_slave_in_master_out(src[20]), .spi_second_simo_oe(src[21]), .spi_second_simo_in(per_in[2]),
		.capture_unit_three(src[22]), .capture_unit_three_oe(src[23]), .capture_unit_three_in(per_in[1]),
		.capture_unit_four(src[24]), .capture_unit_four_oe(src[25]), .capture_unit_four_in(per_in[0]),
		.adc_start_conv_a_out(src[26]), .adc_start_conv_b_out(src[27])
	);
	// ------
	// model
	// ------
	function automatic logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	function automatic int fs(int p);
		return (m_sel >> (2 * p)) & 3;
	endfunction : fs
	// source bit per pin and code; enable -1 drives, -2 leaves the pad free
	function automatic logic [1:0] drv(int p, int c, logic [27:0] s);
		int di [5][4] = '{'{0, 10, 18, 26}, '{1, 11, 19, 22}, '{2, 12, 0, 27}, '{3, 13, 0, 24}, '{4, 0, 18, 20}};
		int oi [5][4] = '{'{5, -1, -1, -1}, '{6, -1, -1, 23}, '{7, -1, -2, -1}, '{8, -1, -2, 25}, '{9, -2, -1, 21}};
		if (c == 1 && m_mode == 3)
			return {1'b1, s[p == 4 ? 17 : 14 + p]};
		return {oi[p][c] == -1 ? 1'b1 : oi[p][c] == -2 ? 1'b0 : s[oi[p][c]], s[di[p][c]]};
	endfunction : drv
	function automatic logic [31:0] exp_rd(logic [31:0] a);
		// pad levels: g still holds, at the answer edge, the synced value taken at the address edge
		return a == PAM_ADDR_FUNC_SEL ? 32'(m_sel << 16) : a == PAM_ADDR_MAP_CFG ? 32'(m_mode) :
			a == PAM_ADDR_PROT ? 32'(m_prot) : a == PAM_ADDR_PIN_LVL ? 32'(g) : 32'h0;
	endfunction : exp_rd
	always @(posedge clk) begin
		rnd <= xs(rnd);
		started <= 1'b1;
		if (!rstn) begin
			e_dr <= '{default: 2'b00};
			{s1, s2, g} <= 15'h0;
			e_in <= 6'h38;
		end else begin
			for (int p = 0; p < 5; p++)
				e_dr[p] <= drv(p, fs(p), src);
			{s1, s2, g} <= {pin_in, s1, s2};
			e_in <= {fs(4) == 1 && m_mode != 3 ? s2[4] : 1'b1, fs(2) == 2 ? s2[2] : 1'b1, fs(3) == 2 ? s2[3] : 1'b1,
				fs(4) == 3 && s2[4], fs(1) == 3 && s2[1], fs(3) == 3 && s2[3]};
		end
	end
	always @(negedge clk) begin
		if (started) begin
			for (int p = 0; p < 5; p++) begin
				`CHK(pin_oe_n[p], ~e_dr[p][1])
				if (e_dr[p][1]) `CHK(pin_out[p], e_dr[p][0])
			end
			`CHK(gpio_in, g)
			`CHK(per_in, e_in)
		end
	end
	// ------
	// bus
	// ------
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= PAM_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
		`CHK(hresp, PAM_HRESP_OKAY)
		if (w && a == PAM_ADDR_PROT) m_prot <= int'(d[0]);
		if (w && m_prot != 0 && a == PAM_ADDR_FUNC_SEL) m_sel <= int'(d[25:16]);
		if (w && m_prot != 0 && a == PAM_ADDR_MAP_CFG) m_mode <= int'(d[1:0]);
	endtask : bus
	task automatic rchk(input logic [31:0] a);
		bus(1'b0, a, 32'h0);
		`CHK(rd, exp_rd(a))
	endtask : rchk
	task automatic wrap_up;
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		foreach (regs[i]) rchk(regs[i]);
		bus(1'b1, PAM_ADDR_FUNC_SEL, 32'hffff_ffff);
		rchk(PAM_ADDR_FUNC_SEL);
		bus(1'b1, PAM_ADDR_PROT, 32'h1);
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, PAM_ADDR_MAP_CFG, 32'(m));
			for (int c = 0; c < 4; c++) begin
				bus(1'b1, PAM_ADDR_FUNC_SEL, {6'h0, {5{2'(c)}}, 16'h0});
				repeat (20) @(posedge clk);
				rchk(PAM_ADDR_FUNC_SEL);
			end
		end
		repeat (40) begin
			bus(1'b1, PAM_ADDR_FUNC_SEL, rnd);
			bus(1'b1, PAM_ADDR_MAP_CFG, rnd);
			repeat (6) @(posedge clk);
			rchk(PAM_ADDR_FUNC_SEL);
			rchk(PAM_ADDR_MAP_CFG);
		end
		bus(1'b1, 32'h10, 32'hffff_ffff);
		bus(1'b1, PAM_ADDR_PIN_LVL, 32'hffff_ffff);
		bus(1'b1, PAM_ADDR_PROT, 32'h0);
		bus(1'b1, PAM_ADDR_FUNC_SEL, 32'h0155_0000);
		foreach (regs[i]) rchk(regs[i]);
		rstn <= 1'b0;
		m_sel <= 0;
		m_mode <= 0;
		m_prot <= 0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		foreach (regs[i]) rchk(regs[i]);
		wrap_up();
	end
	// run is about 1000 cycles; a hang is cut at ten times that
	initial begin
		#100000;
		error_cnt++;
		wrap_up();
	end
endmodule : port_a_pins8_12_func_select_tb
